/* File: hdl/osc_defines.svh */
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// Register indices on the plain register port.
`define OFS_OSC_CTRL 4'h0
`define OFS_CLK_DIV 4'h1
`define OFS_PLL_FBD 4'h2
`define OFS_UNLOCK 4'h3

// Oscillator control layout.
`define BIT_SWITCH_REQ 0
`define BIT_LP_OSC_EN 1
`define BIT_CLK_FAIL 3
`define BIT_PLL_LOCKED 5
`define BIT_PIN_LOCK 6
`define BIT_CLK_LOCK 7
`define NEW_SRC_LSB 8
`define CUR_SRC_LSB 12
`define SRC_W 3

// Clock divisor layout.
`define IN_DIV_LSB 0
`define IN_DIV_W 5
`define OUT_DIV_LSB 6
`define OUT_DIV_W 2
`define FRC_DIV_LSB 8
`define FRC_DIV_W 3
`define DOZE_EN_BIT 11
`define DOZE_LSB 12
`define DOZE_W 3
`define FBD_W 9

// Reset values.
`define SRC_RESET 3'h7
`define IN_DIV_RESET 5'h00
`define OUT_DIV_RESET 2'h1
`define FRC_DIV_RESET 3'h0
`define DOZE_RESET 3'h3
`define FBD_RESET 9'h030

// Unlock keys; the values are arbitrary.
`define UNLOCK_KEY1 16'h5a5a
`define UNLOCK_KEY2 16'ha5a5

// Ratios and timing.
`define RATIO_W 9
`define FAST_RC_DIV16_RATIO 9'h010
`define CPU_RATIO 9'h002
`define CLK_PERIOD_NS 4
`define PLL_LOCK_TIME_NS 2000
`define PLL_LOCK_CYCLES ((`PLL_LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hdl/osc_pkg.sv */
package osc_pkg;
	typedef enum logic [2:0] {
		SRC_FAST_RC = 3'b000,
		SRC_FAST_RC_PLL = 3'b001,
		SRC_PRIMARY = 3'b010,
		SRC_PRIMARY_PLL = 3'b011,
		SRC_SECONDARY = 3'b100,
		SRC_LOW_POWER_RC = 3'b101,
		SRC_FAST_RC_DIV16 = 3'b110,
		SRC_FAST_RC_DIVN = 3'b111
	} osc_source_t;
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_WAIT_READY = 2'b01,
		SW_ALIGN = 2'b10
	} switch_state_t;
endpackage

/* File: hdl/pulse_divider.sv */
`timescale 1ns/1ps
module pulse_divider #(
	parameter int W = 9
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Rate in and out
	input wire logic en_i,
	input wire logic [W-1:0] ratio_i,
	output logic tick_o
);
	logic [W-1:0] cnt_reg;
	logic last;

	// A ratio of zero behaves as one, so the output never stops.
	assign last = (ratio_i <= W'(1)) || (cnt_reg >= ratio_i - W'(1));
	assign tick_o = en_i && last;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= '0;
		end else if (en_i) begin
			cnt_reg <= last ? '0 : cnt_reg + W'(1);
		end
	end
endmodule // pulse_divider

/* File: hdl/pll_ratio_lock.sv */
`timescale 1ns/1ps
module pll_ratio_lock #(
	parameter int LOCK_CYCLES = 500
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Divider fields
	input wire logic [8:0] feedback_i,
	input wire logic [4:0] input_div_i,
	input wire logic [1:0] output_div_i,
	// Control and lock
	input wire logic enable_i,
	input wire logic restart_i,
	input wire logic lock_i,
	output logic [9:0] mult_o,
	output logic [5:0] input_ratio_o,
	output logic [3:0] output_ratio_o,
	output logic [9:0] osc_den_o,
	output logic locked_o
);
	localparam int CW = $clog2(LOCK_CYCLES + 1);
	logic [CW-1:0] timer_reg;

	assign mult_o = {1'b0, feedback_i} + 10'h002;
	assign input_ratio_o = {1'b0, input_div_i} + 6'h02;
	assign output_ratio_o = {1'b0, output_div_i, 1'b0} + 4'h2;
	assign osc_den_o = 10'(input_ratio_o) * 10'(output_ratio_o);

	// The timer restarts on any divider change, since lock is lost then.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			timer_reg <= '0;
		end else if (!enable_i || restart_i) begin
			timer_reg <= '0;
		end else if (timer_reg != CW'(LOCK_CYCLES)) begin
			timer_reg <= timer_reg + CW'(1);
		end
	end

	assign locked_o = enable_i && (lock_i || timer_reg == CW'(LOCK_CYCLES));
endmodule // pll_ratio_lock

/* File: hdl/oscillator_select_and_switch.sv */
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "osc_defines.svh"
module oscillator_select_and_switch
	import osc_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0,
	parameter int PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
	// Clock, power-on reset and other resets
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic soft_reset_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Configuration straps
	input wire logic [2:0] initial_source_config_i,
	input wire logic [1:0] primary_mode_config_i,
	input wire logic switch_monitor_config_bit0_i,
	// Source rate pulses and readiness
	input wire logic fast_rc_tick_i,
	input wire logic primary_tick_i,
	input wire logic low_power_rc_tick_i,
	input wire logic secondary_tick_i,
	input wire logic pll_tick_i,
	input wire logic primary_ready_i,
	input wire logic secondary_ready_i,
	input wire logic low_power_rc_ready_i,
	input wire logic pll_lock_i,
	input wire logic clock_fail_i,
	// Clock rates
	output logic osc_tick_o,
	output logic cpu_tick_o,
	output logic peripheral_tick_o,
	// Oscillator controls
	output logic [2:0] current_source_o,
	output logic primary_enable_o,
	output logic [1:0] primary_mode_o,
	output logic pll_enable_o,
	output logic pll_from_primary_o,
	output logic [9:0] pll_mult_o,
	output logic [5:0] input_divide_ratio_o,
	output logic [3:0] output_divide_ratio_o,
	output logic [9:0] pll_osc_den_o,
	output logic low_power_osc_enable_o,
	output logic pin_config_lock_o,
	output logic osc_fail_trap_o,
	output logic switch_busy_o
);
	osc_source_t cur_src_reg;
	osc_source_t new_src_reg;
	switch_state_t sw_state_reg;
	logic loaded_reg;
	logic switch_req_reg;
	logic clk_lock_reg;
	logic pin_lock_reg;
	logic clock_fail_reg;
	logic lp_osc_en_reg;
	logic [1:0] unlock_reg;
	logic [`IN_DIV_W-1:0] in_div_reg;
	logic [`OUT_DIV_W-1:0] out_div_reg;
	logic [`FRC_DIV_W-1:0] frc_div_reg;
	logic doze_en_reg;
	logic [`DOZE_W-1:0] doze_reg;
	logic [`FBD_W-1:0] fbd_reg;
	logic [15:0] rdata_reg;
	logic trap_reg;
	logic cfg_locked;
	logic osc_wr;
	logic div_wr;
	logic fbd_wr;
	logic unlock_wr;
	logic fail_event;
	logic switch_done;
	logic pll_locked;
	logic pll_on;
	logic new_ready;
	logic frc_n_tick;
	logic frc16_tick;
	logic base_tick;
	logic doze_tick;
	logic [`RATIO_W-1:0] frc_ratio;
	logic [`RATIO_W-1:0] doze_ratio;

	function automatic osc_source_t map_src(input osc_source_t s);
		map_src = (SMALL_PACKAGE && s == SRC_SECONDARY) ? SRC_FAST_RC_DIVN : s;
	endfunction

	function automatic logic uses_pll(input osc_source_t s);
		uses_pll = (s == SRC_FAST_RC_PLL) || (s == SRC_PRIMARY_PLL);
	endfunction

	assign cfg_locked = clk_lock_reg && switch_monitor_config_bit0_i;

	assign osc_wr = wr_i && loaded_reg && addr_i == `OFS_OSC_CTRL && unlock_reg == 2'h2;
	assign div_wr = wr_i && !cfg_locked && addr_i == `OFS_CLK_DIV;
	assign fbd_wr = wr_i && !cfg_locked && addr_i == `OFS_PLL_FBD;
	assign unlock_wr = wr_i && addr_i == `OFS_UNLOCK;

	// written one acts as a failure
	assign fail_event = clock_fail_i || (osc_wr && wdata_i[`BIT_CLK_FAIL]);

	// Each unlock arms only the next write, and only a control write makes use of it.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			unlock_reg <= 2'h0;
		end else if (soft_reset_i) begin
			unlock_reg <= 2'h0;
		end else if (unlock_wr && wdata_i == `UNLOCK_KEY1) begin
			unlock_reg <= 2'h1;
		end else if (unlock_wr && wdata_i == `UNLOCK_KEY2 && unlock_reg == 2'h1) begin
			unlock_reg <= 2'h2;
		end else if (wr_i) begin
			unlock_reg <= 2'h0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			new_src_reg <= osc_source_t'(`SRC_RESET);
		end else if (!loaded_reg) begin
			new_src_reg <= osc_source_t'(initial_source_config_i);
		end else if (osc_wr && !cfg_locked) begin
			new_src_reg <= osc_source_t'(wdata_i[`NEW_SRC_LSB +: `SRC_W]);
		end
	end

	// these registers see only the power-on reset
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_lock_reg <= 1'b0;
			pin_lock_reg <= 1'b0;
			lp_osc_en_reg <= 1'b0;
		end else if (osc_wr) begin
			clk_lock_reg <= wdata_i[`BIT_CLK_LOCK];
			pin_lock_reg <= wdata_i[`BIT_PIN_LOCK];
			lp_osc_en_reg <= wdata_i[`BIT_LP_OSC_EN];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clock_fail_reg <= 1'b0;
		end else if (fail_event) begin
			clock_fail_reg <= 1'b1;
		end else if (osc_wr) begin
			clock_fail_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trap_reg <= 1'b0;
		end else begin
			trap_reg <= fail_event;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			switch_req_reg <= 1'b0;
		end else if (osc_wr && !cfg_locked && wdata_i[`BIT_SWITCH_REQ]) begin
			switch_req_reg <= 1'b1;
		end else if (switch_done) begin
			switch_req_reg <= 1'b0;
		end
	end

	// Divider fields; doze writes follow the doze enable interlocks.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			in_div_reg <= `IN_DIV_RESET;
			out_div_reg <= `OUT_DIV_RESET;
			frc_div_reg <= `FRC_DIV_RESET;
			doze_reg <= `DOZE_RESET;
			doze_en_reg <= 1'b0;
		end else if (div_wr) begin
			in_div_reg <= wdata_i[`IN_DIV_LSB +: `IN_DIV_W];
			out_div_reg <= wdata_i[`OUT_DIV_LSB +: `OUT_DIV_W];
			frc_div_reg <= wdata_i[`FRC_DIV_LSB +: `FRC_DIV_W];
			if (!doze_en_reg) begin
				doze_reg <= wdata_i[`DOZE_LSB +: `DOZE_W];
			end
			doze_en_reg <= wdata_i[`DOZE_EN_BIT] && (doze_reg != '0);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fbd_reg <= `FBD_RESET;
		end else if (fbd_wr) begin
			fbd_reg <= wdata_i[`FBD_W-1:0];
		end
	end

	always_comb begin
		new_ready = 1'b1;
		unique case (map_src(new_src_reg))
			SRC_FAST_RC, SRC_FAST_RC_DIV16, SRC_FAST_RC_DIVN: new_ready = 1'b1;
			SRC_FAST_RC_PLL: new_ready = pll_locked;
			SRC_PRIMARY: new_ready = primary_ready_i;
			SRC_PRIMARY_PLL: new_ready = primary_ready_i && pll_locked;
			SRC_SECONDARY: new_ready = secondary_ready_i;
			SRC_LOW_POWER_RC: new_ready = low_power_rc_ready_i;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sw_state_reg <= SW_IDLE;
		end else begin
			unique case (sw_state_reg)
				SW_IDLE: begin
					if (switch_req_reg && !switch_done) begin
						sw_state_reg <= SW_WAIT_READY;
					end
				end
				SW_WAIT_READY: begin
					if (new_ready) begin
						sw_state_reg <= SW_ALIGN;
					end
				end
				SW_ALIGN: begin
					if (switch_done) begin
						sw_state_reg <= SW_IDLE;
					end
				end
				default: sw_state_reg <= SW_IDLE;
			endcase
		end
	end

	// A failed old source never ticks, so a set fail flag skips alignment.
	assign switch_done = switch_req_reg && (
		(sw_state_reg == SW_IDLE && new_src_reg == cur_src_reg) ||
		(sw_state_reg == SW_ALIGN && (osc_tick_o || clock_fail_reg)));

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur_src_reg <= osc_source_t'(`SRC_RESET);
		end else if (!loaded_reg) begin
			cur_src_reg <= osc_source_t'(initial_source_config_i);
		end else if (switch_done) begin
			cur_src_reg <= new_src_reg;
		end
	end

	always_comb begin
		osc_tick_o = 1'b0;
		unique case (map_src(cur_src_reg))
			SRC_FAST_RC: osc_tick_o = fast_rc_tick_i;
			SRC_FAST_RC_PLL, SRC_PRIMARY_PLL: osc_tick_o = pll_tick_i;
			SRC_PRIMARY: osc_tick_o = primary_tick_i;
			SRC_SECONDARY: osc_tick_o = secondary_tick_i;
			SRC_LOW_POWER_RC: osc_tick_o = low_power_rc_tick_i;
			SRC_FAST_RC_DIV16: osc_tick_o = frc16_tick;
			SRC_FAST_RC_DIVN: osc_tick_o = frc_n_tick;
		endcase
	end

	// Postscaler code 7 divides by 256, the others by two to the code.
	assign frc_ratio = (`RATIO_W'(1)) << (frc_div_reg == 3'h7 ? 4'h8 : {1'b0, frc_div_reg});
	assign doze_ratio = (`RATIO_W'(1)) << doze_reg;

	pulse_divider #(.W(`RATIO_W)) u_frc_n (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(fast_rc_tick_i),
		.ratio_i(frc_ratio),
		.tick_o(frc_n_tick)
	);

	pulse_divider #(.W(`RATIO_W)) u_frc16 (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(fast_rc_tick_i),
		.ratio_i(`FAST_RC_DIV16_RATIO),
		.tick_o(frc16_tick)
	);

	pulse_divider #(.W(`RATIO_W)) u_cpu (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(osc_tick_o),
		.ratio_i(`CPU_RATIO),
		.tick_o(base_tick)
	);

	pulse_divider #(.W(`RATIO_W)) u_doze (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.en_i(base_tick),
		.ratio_i(doze_ratio),
		.tick_o(doze_tick)
	);

	assign peripheral_tick_o = base_tick;
	assign cpu_tick_o = doze_en_reg ? doze_tick : base_tick;

	// The PLL stays on while either side of a switch needs it.
	assign pll_on = uses_pll(cur_src_reg) || (switch_req_reg && uses_pll(new_src_reg));

	pll_ratio_lock #(.LOCK_CYCLES(PLL_LOCK_CYCLES)) u_pll (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.feedback_i(fbd_reg),
		.input_div_i(in_div_reg),
		.output_div_i(out_div_reg),
		.enable_i(pll_on),
		.restart_i(div_wr || fbd_wr),
		.lock_i(pll_lock_i),
		.mult_o(pll_mult_o),
		.input_ratio_o(input_divide_ratio_o),
		.output_ratio_o(output_divide_ratio_o),
		.osc_den_o(pll_osc_den_o),
		.locked_o(pll_locked)
	);

	// primary mode only for primary codes
	assign primary_enable_o = (cur_src_reg == SRC_PRIMARY) || (cur_src_reg == SRC_PRIMARY_PLL) ||
		(switch_req_reg && (new_src_reg == SRC_PRIMARY || new_src_reg == SRC_PRIMARY_PLL));
	assign primary_mode_o = primary_enable_o ? primary_mode_config_i : 2'h0;
	assign pll_enable_o = pll_on;
	assign pll_from_primary_o = switch_req_reg ? (new_src_reg == SRC_PRIMARY_PLL) :
		(cur_src_reg == SRC_PRIMARY_PLL);
	assign current_source_o = cur_src_reg;
	assign low_power_osc_enable_o = lp_osc_en_reg;
	assign pin_config_lock_o = pin_lock_reg;
	assign osc_fail_trap_o = trap_reg;
	assign switch_busy_o = switch_req_reg;

	// Read data appear one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_reg <= 16'h0000;
		end else if (rd_i) begin
			unique case (addr_i)
				`OFS_OSC_CTRL: rdata_reg <= {1'b0, cur_src_reg, 1'b0, new_src_reg,
					clk_lock_reg, pin_lock_reg, pll_locked, 1'b0,
					clock_fail_reg, 1'b0, lp_osc_en_reg, switch_req_reg};
				`OFS_CLK_DIV: rdata_reg <= {1'b0, doze_reg, doze_en_reg, frc_div_reg,
					out_div_reg, 1'b0, in_div_reg};
				`OFS_PLL_FBD: rdata_reg <= {7'h00, fbd_reg};
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end

	assign rdata_o = rdata_reg;
endmodule // oscillator_select_and_switch

/* File: dv/osc_switch_checker.sv */
`timescale 1ns/1ps
module osc_switch_checker
	import osc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register port
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Failure input
	input wire logic clock_fail_i,
	// Clock rates
	input wire logic osc_tick_o,
	input wire logic cpu_tick_o,
	input wire logic peripheral_tick_o,
	// Oscillator controls
	input wire logic [2:0] current_source_o,
	input wire logic primary_enable_o,
	input wire logic [1:0] primary_mode_o,
	input wire logic [5:0] input_divide_ratio_o,
	input wire logic [3:0] output_divide_ratio_o,
	input wire logic [9:0] pll_osc_den_o,
	input wire logic low_power_osc_enable_o,
	input wire logic pin_config_lock_o,
	input wire logic osc_fail_trap_o,
	input wire logic switch_busy_o
);
	logic [1:0] run_reg;
	logic fail_cause_reg;

	// The first edges after reset load the straps, so change checks wait two edges.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_reg <= 2'h0;
		end else begin
			run_reg <= {run_reg[0], 1'b1};
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fail_cause_reg <= 1'b0;
		end else begin
			fail_cause_reg <= clock_fail_i | (wr_i & (addr_i == 4'h0) & wdata_i[3]);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_periph_on_osc: assert property (peripheral_tick_o |-> osc_tick_o)
		else $error("peripheral tick without oscillator tick");
	a_cpu_on_periph: assert property (cpu_tick_o |-> peripheral_tick_o)
		else $error("cpu tick without peripheral tick");
	a_den_product: assert property (pll_osc_den_o == 10'(input_divide_ratio_o) * 10'(output_divide_ratio_o))
		else $error("pll denominator is not the product of the ratios");
	a_fail_trap: assert property (clock_fail_i |=> osc_fail_trap_o)
		else $error("clock failure raised no trap");
	a_trap_cause: assert property (osc_fail_trap_o |-> fail_cause_reg)
		else $error("trap without failure or flag write");
	a_source_hold: assert property (run_reg[1] && $changed(current_source_o) |-> $past(switch_busy_o))
		else $error("current source changed without a switch request");
	a_rdata_hold: assert property (run_reg[1] && !$past(rd_i) |-> $stable(rdata_o))
		else $error("read data changed without a read");
	a_pin_lock_write: assert property (run_reg[1] && $changed(pin_config_lock_o) |-> $past(wr_i) && $past(addr_i) == 4'h0)
		else $error("pin lock changed without a control write");
	a_lposc_write: assert property (run_reg[1] && $changed(low_power_osc_enable_o) |-> $past(wr_i) && $past(addr_i) == 4'h0)
		else $error("low power enable changed without a control write");
	a_primary_off: assert property (!primary_enable_o |-> primary_mode_o == 2'b00)
		else $error("primary mode driven while primary is off");
endmodule // osc_switch_checker

bind oscillator_select_and_switch osc_switch_checker osc_switch_checker_inst (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .clock_fail_i(clock_fail_i), .osc_tick_o(osc_tick_o),
	.cpu_tick_o(cpu_tick_o), .peripheral_tick_o(peripheral_tick_o),
	.current_source_o(current_source_o), .primary_enable_o(primary_enable_o),
	.primary_mode_o(primary_mode_o), .input_divide_ratio_o(input_divide_ratio_o),
	.output_divide_ratio_o(output_divide_ratio_o), .pll_osc_den_o(pll_osc_den_o),
	.low_power_osc_enable_o(low_power_osc_enable_o), .pin_config_lock_o(pin_config_lock_o),
	.osc_fail_trap_o(osc_fail_trap_o), .switch_busy_o(switch_busy_o)
);

/* File: dv/oscillator_select_and_switch_tb_top.sv */
`timescale 1ns/1ps
`include "osc_defines.svh"
module oscillator_select_and_switch_tb_top
	import osc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic [2:0] initial_source_config_i = SRC_PRIMARY;
	logic [1:0] primary_mode_config_i = 2'b01;
	logic switch_monitor_config_bit0_i = 1'b1;
	logic fast_rc_tick_i = 1'b0;
	logic primary_tick_i = 1'b0;
	logic low_power_rc_tick_i = 1'b0;
	logic secondary_tick_i = 1'b0;
	logic pll_tick_i = 1'b0;
	logic primary_ready_i = 1'b1;
	logic secondary_ready_i = 1'b1;
	logic low_power_rc_ready_i = 1'b1;
	logic pll_lock_i = 1'b1;
	logic clock_fail_i = 1'b0;
	logic [15:0] rdata_o;
	logic osc_tick_o, cpu_tick_o, peripheral_tick_o, primary_enable_o, pll_enable_o;
	logic pll_from_primary_o, low_power_osc_enable_o, pin_config_lock_o, osc_fail_trap_o;
	logic switch_busy_o;
	logic [2:0] current_source_o;
	logic [1:0] primary_mode_o;
	logic [9:0] pll_mult_o, pll_osc_den_o;
	logic [5:0] input_divide_ratio_o;
	logic [3:0] output_divide_ratio_o;
	logic [3:0] tick_cnt = 4'h0;
	logic [15:0] rd_val;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;

	// A short lock timer keeps the PLL switches quick.
	oscillator_select_and_switch #(.SMALL_PACKAGE(1'b0), .PLL_LOCK_CYCLES(4))
	oscillator_select_and_switch_inst (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .soft_reset_i(soft_reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.initial_source_config_i(initial_source_config_i),
		.primary_mode_config_i(primary_mode_config_i),
		.switch_monitor_config_bit0_i(switch_monitor_config_bit0_i),
		.fast_rc_tick_i(fast_rc_tick_i), .primary_tick_i(primary_tick_i),
		.low_power_rc_tick_i(low_power_rc_tick_i), .secondary_tick_i(secondary_tick_i),
		.pll_tick_i(pll_tick_i), .primary_ready_i(primary_ready_i),
		.secondary_ready_i(secondary_ready_i), .low_power_rc_ready_i(low_power_rc_ready_i),
		.pll_lock_i(pll_lock_i), .clock_fail_i(clock_fail_i), .osc_tick_o(osc_tick_o),
		.cpu_tick_o(cpu_tick_o), .peripheral_tick_o(peripheral_tick_o),
		.current_source_o(current_source_o), .primary_enable_o(primary_enable_o),
		.primary_mode_o(primary_mode_o), .pll_enable_o(pll_enable_o),
		.pll_from_primary_o(pll_from_primary_o), .pll_mult_o(pll_mult_o),
		.input_divide_ratio_o(input_divide_ratio_o),
		.output_divide_ratio_o(output_divide_ratio_o), .pll_osc_den_o(pll_osc_den_o),
		.low_power_osc_enable_o(low_power_osc_enable_o),
		.pin_config_lock_o(pin_config_lock_o), .osc_fail_trap_o(osc_fail_trap_o),
		.switch_busy_o(switch_busy_o)
	);

	always #2 clk_i = ~clk_i;

	// Fast RC ticks every second cycle, the slower sources every fourth.
	always @(posedge clk_i) begin
		tick_cnt <= tick_cnt + 4'h1;
		fast_rc_tick_i <= tick_cnt[0];
		primary_tick_i <= (tick_cnt[1:0] == 2'h0);
		low_power_rc_tick_i <= (tick_cnt[1:0] == 2'h1);
		secondary_tick_i <= (tick_cnt[1:0] == 2'h2);
		pll_tick_i <= (tick_cnt[1:0] == 2'h3);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic ctrl_wr(input logic [15:0] d);
		reg_wr(`OFS_UNLOCK, `UNLOCK_KEY1);
		reg_wr(`OFS_UNLOCK, `UNLOCK_KEY2);
		reg_wr(`OFS_OSC_CTRL, d);
	endtask

	task automatic do_switch(input logic [2:0] s);
		logic pll;
		pll = (s == SRC_FAST_RC_PLL) || (s == SRC_PRIMARY_PLL);
		ctrl_wr({5'h00, s, 8'h43});
		for (int i = 0; i < 200 && switch_busy_o !== 1'b0; i++) @(posedge clk_i);
		#1;
		check(16'(switch_busy_o), 16'h0000);
		check(16'(current_source_o), 16'(s));
		check(16'(pll_enable_o), 16'(pll));
		check(16'(pll_from_primary_o), 16'(s == SRC_PRIMARY_PLL));
		check(16'(primary_enable_o), 16'(s == SRC_PRIMARY || s == SRC_PRIMARY_PLL));
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, {1'b0, s, 1'b0, s, 8'h42 | (pll ? 8'h20 : 8'h00)});
	endtask

	task automatic t_reset;
		repeat (6) @(posedge clk_i);
		check(16'(current_source_o), 16'(SRC_FAST_RC_DIVN));
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h2200);
		check(16'(primary_mode_o), 16'h0001);
		$display("reset test done");
	endtask

	task automatic t_unlock;
		reg_wr(`OFS_OSC_CTRL, 16'h0242);
		check(16'(pin_config_lock_o), 16'h0000);
		ctrl_wr(16'h0542);
		check(16'(pin_config_lock_o), 16'h0001);
		check(16'(low_power_osc_enable_o), 16'h0001);
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h2542);
		reg_rd(4'h9, rd_val);
		check(rd_val, 16'h0000);
		$display("unlock test done");
	endtask

	task automatic t_pll;
		reg_wr(`OFS_CLK_DIV, 16'h0043);
		reg_wr(`OFS_PLL_FBD, 16'h0030);
		check(16'(pll_mult_o), 16'h0032);
		check(16'(input_divide_ratio_o), 16'h0005);
		check(16'(output_divide_ratio_o), 16'h0004);
		check(16'(pll_osc_den_o), 16'h0014);
		$display("pll ratio test done");
	endtask

	task automatic t_switch;
		int osc_n;
		int cpu_n;
		int per_n;
		osc_n = 0;
		cpu_n = 0;
		per_n = 0;
		// Without the lock input the PLL sources must wait for the start-up timer.
		@(posedge clk_i);
		pll_lock_i <= 1'b0;
		for (int s = 0; s < 8; s++) do_switch(3'(s));
		repeat (400) begin
			@(negedge clk_i);
			osc_n += osc_tick_o;
			cpu_n += cpu_tick_o;
		end
		check(16'(osc_n), 16'h00c8);
		check(16'(osc_n >= 2 * cpu_n && osc_n <= 2 * cpu_n + 1), 16'h0001);
		reg_wr(`OFS_CLK_DIV, 16'h1043);
		reg_wr(`OFS_CLK_DIV, 16'h1843);
		cpu_n = 0;
		repeat (400) begin
			@(negedge clk_i);
			per_n += peripheral_tick_o;
			cpu_n += cpu_tick_o;
		end
		check(16'(per_n), 16'h0064);
		check(16'(cpu_n), 16'h0032);
		reg_wr(`OFS_CLK_DIV, 16'h0043);
		$display("switch test done");
	endtask

	task automatic t_lock;
		ctrl_wr(16'h07c2);
		ctrl_wr(16'h05c2);
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h77c2);
		reg_wr(`OFS_CLK_DIV, 16'h0000);
		check(16'(input_divide_ratio_o), 16'h0005);
		@(posedge clk_i);
		switch_monitor_config_bit0_i <= 1'b0;
		ctrl_wr(16'h05c2);
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h75c2);
		ctrl_wr(16'h0742);
		$display("lock test done");
	endtask

	task automatic t_fail;
		ctrl_wr(16'h074a);
		check(16'(osc_fail_trap_o), 16'h0001);
		ctrl_wr(16'h0742);
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h7742);
		@(posedge clk_i);
		clock_fail_i <= 1'b1;
		@(posedge clk_i);
		clock_fail_i <= 1'b0;
		#1;
		check(16'(osc_fail_trap_o), 16'h0001);
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h774a);
		ctrl_wr(16'h0742);
		$display("failure test done");
	endtask

	task automatic t_soft;
		@(posedge clk_i);
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		reg_rd(`OFS_OSC_CTRL, rd_val);
		check(rd_val, 16'h7742);
		$display("soft reset test done");
	endtask

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		t_reset();
		t_unlock();
		t_pll();
		t_switch();
		t_lock();
		t_fail();
		t_soft();
		finish_test();
	end
endmodule // oscillator_select_and_switch_tb_top
